// ---- uvh_pkg.sv ----
// Constants, types and helpers for the input undervoltage fault handler
package uvh_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_INPUT_LOW_WARNING_THRESHOLD = 8'h58;
  localparam logic [7:0] CMD_INPUT_LOW_FAULT_THRESHOLD = 8'h59;
  localparam logic [7:0] CMD_INPUT_LOW_FAULT_REACTION = 8'h5a;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WARNING_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_FAULT_THRESHOLD = 16'h0000;
  localparam logic [7:0] RST_FAULT_REACTION = 8'h00;

  // ----------------------------------------------------------------
  // Reaction byte fields
  // ----------------------------------------------------------------
  localparam int REACT_MODE_LSB = 6;
  localparam int REACT_RETRY_LSB = 3;
  localparam int REACT_DELAY_LSB = 0;

  localparam logic [1:0] MODE_IGNORE = 2'b00;
  localparam logic [1:0] MODE_RUN_THEN_RETRY = 2'b01;
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'b10;
  localparam logic [1:0] MODE_DISABLE_RESUME = 2'b11;

  localparam logic [2:0] RETRY_NONE = 3'b000;
  localparam logic [2:0] RETRY_FOREVER = 3'b111;

  // ----------------------------------------------------------------
  // Handler states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_CONTINUE = 3'b001,
    ST_RETRY_WAIT = 3'b010,
    ST_LATCHED = 3'b011,
    ST_RESUME_WAIT = 3'b100
  } uvh_state_e;

  // Number of time units for a delay code: two to the code
  function automatic logic [7:0] uvh_units(input logic [2:0] code);
    uvh_units = 8'h01 << code;
  endfunction : uvh_units

  // Linear value (5-bit exponent, 11-bit mantissa) to fixed point, 16 frac
  function automatic logic signed [47:0] uvh_lin_to_fix(
    input logic [15:0] lin
  );
    logic signed [5:0] sh;
    logic signed [47:0] m;
    sh = {lin[15], lin[15:11]};
    m = {{37{lin[10]}}, lin[10:0]} <<< 16;
    if (sh < 0) begin
      uvh_lin_to_fix = m >>> (-sh);
    end else begin
      uvh_lin_to_fix = m <<< sh;
    end
  endfunction : uvh_lin_to_fix

endpackage : uvh_pkg

// ---- uvh_timer_if.sv ----
// Link between the fault handler and its delay timer
`timescale 1ns/1ps
interface uvh_timer_if #(
  parameter int UNIT_W = 16
);
  logic start;
  logic [2:0] code;
  logic [UNIT_W-1:0] unitCycles;
  logic expired;

  modport ctrl (
    output start,
    output code,
    output unitCycles,
    input expired
  );
  modport timer (
    input start,
    input code,
    input unitCycles,
    output expired
  );
endinterface : uvh_timer_if

// ---- uvh_delay_timer.sv ----
// Power-of-two count of programmable time units
`timescale 1ns/1ps
module uvh_delay_timer
  import uvh_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Handler side
  uvh_timer_if.timer tmr
);

  logic running_r;
  logic [2:0] code_r;
  logic [UNIT_W-1:0] unitCnt_r;
  logic [7:0] tally_r;

  // ----------------------------------------------------------------
  // Terminal counts
  // ----------------------------------------------------------------
  wire logic unitLast;
  wire logic tallyLast;
  assign unitLast = ({1'b0, unitCnt_r} + {{UNIT_W{1'b0}}, 1'b1})
                    >= {1'b0, tmr.unitCycles};
  assign tallyLast = tally_r == (uvh_units(code_r) - 8'h01);
  assign tmr.expired = running_r & unitLast & tallyLast;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || tmr.start || !running_r || unitLast) begin
      unitCnt_r <= '0;
    end else begin
      unitCnt_r <= unitCnt_r + {{(UNIT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      running_r <= 1'b0;
      code_r <= 3'h0;
      tally_r <= 8'h00;
    end else if (tmr.start) begin
      running_r <= 1'b1;
      code_r <= tmr.code;
      tally_r <= 8'h00;
    end else if (tmr.expired) begin
      running_r <= 1'b0;
    end else if (running_r && unitLast) begin
      tally_r <= tally_r + 8'h01;
    end
  end

endmodule : uvh_delay_timer

// ---- uvh_input_low_fault.sv ----
// Input undervoltage warning, fault detection and fault reaction
`timescale 1ns/1ps
module uvh_input_low_fault
  import uvh_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command port
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWdata,
  output logic [15:0] cmdRdata,
  output logic cmdRdValid,
  output logic cmdUnsupported,
  // Measurement and configuration from elsewhere in the device
  input wire logic [15:0] vinMeas,
  input wire logic [UNIT_W-1:0] timeUnitCycles,
  input wire logic hybridRatioRegulationEnable,
  // Device control
  input wire logic offCommand,
  input wire logic otherFaultShutdown,
  input wire logic faultClear,
  // Status and control out
  output logic outputEnable,
  output logic inputLowWarning,
  output logic inputLowFault,
  output logic hybridRatioRegulationActive,
  output logic retryActive,
  output logic [2:0] retryAttemptCount
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] inputLowWarningThreshold_r;
  logic [15:0] inputLowFaultThreshold_r;
  logic [7:0] inputLowFaultReaction_r;
  logic [15:0] cmdRdata_r;
  logic cmdRdValid_r;
  logic cmdUnsupported_r;
  logic inputLowWarning_r;
  logic inputLowFault_r;
  logic hybridRatioRegulationActive_r;
  uvh_state_e state_r;
  uvh_state_e state_nxt;
  logic [2:0] attempts_r;
  logic [2:0] attempts_nxt;
  logic timerStart;

  uvh_timer_if #(.UNIT_W(UNIT_W)) tmrBus ();

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic hitWarn;
  wire logic hitFault;
  wire logic hitReact;
  wire logic hitAny;
  wire logic [15:0] readMux;
  assign hitWarn = cmdCode == CMD_INPUT_LOW_WARNING_THRESHOLD;
  assign hitFault = cmdCode == CMD_INPUT_LOW_FAULT_THRESHOLD;
  assign hitReact = cmdCode == CMD_INPUT_LOW_FAULT_REACTION;
  assign hitAny = hitWarn | hitFault | hitReact;
  assign readMux = hitWarn ? inputLowWarningThreshold_r :
                   hitFault ? inputLowFaultThreshold_r :
                   hitReact ? {8'h00, inputLowFaultReaction_r} : 16'h0000;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      inputLowWarningThreshold_r <= RST_WARNING_THRESHOLD;
      inputLowFaultThreshold_r <= RST_FAULT_THRESHOLD;
      inputLowFaultReaction_r <= RST_FAULT_REACTION;
    end else if (cmdWrite) begin
      if (hitWarn) begin
        inputLowWarningThreshold_r <= cmdWdata;
      end
      if (hitFault) begin
        inputLowFaultThreshold_r <= cmdWdata;
      end
      if (hitReact) begin
        inputLowFaultReaction_r <= cmdWdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmdRdata_r <= 16'h0000;
      cmdRdValid_r <= 1'b0;
      cmdUnsupported_r <= 1'b0;
    end else begin
      cmdRdValid_r <= cmdRead;
      cmdUnsupported_r <= (cmdRead | cmdWrite) & ~hitAny;
      if (cmdRead) begin
        cmdRdata_r <= readMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reaction fields
  // ----------------------------------------------------------------
  wire logic [1:0] reactMode;
  wire logic [2:0] retrySetting;
  wire logic [2:0] delayCode;
  assign reactMode = inputLowFaultReaction_r[REACT_MODE_LSB +: 2];
  assign retrySetting = inputLowFaultReaction_r[REACT_RETRY_LSB +: 3];
  assign delayCode = inputLowFaultReaction_r[REACT_DELAY_LSB +: 3];

  // ----------------------------------------------------------------
  // Threshold comparison
  // ----------------------------------------------------------------
  wire logic signed [47:0] vinFix;
  wire logic signed [47:0] warnFix;
  wire logic signed [47:0] faultFix;
  wire logic belowWarn;
  wire logic belowFault;
  assign vinFix = uvh_lin_to_fix(vinMeas);
  assign warnFix = uvh_lin_to_fix(inputLowWarningThreshold_r);
  assign faultFix = uvh_lin_to_fix(inputLowFaultThreshold_r);
  assign belowWarn = vinFix < warnFix;
  assign belowFault = vinFix < faultFix;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      inputLowWarning_r <= 1'b0;
      inputLowFault_r <= 1'b0;
      hybridRatioRegulationActive_r <= 1'b0;
    end else begin
      inputLowWarning_r <= belowWarn;
      inputLowFault_r <= belowFault;
      // Shares the warning threshold, gated by the option bit
      hybridRatioRegulationActive_r <=
        belowWarn & hybridRatioRegulationEnable;
    end
  end

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  assign tmrBus.start = timerStart;
  assign tmrBus.code = delayCode;
  assign tmrBus.unitCycles = timeUnitCycles;

  uvh_delay_timer #(.UNIT_W(UNIT_W)) uDelay (
    .clk(clk),
    .resetn(resetn),
    .tmr(tmrBus.timer)
  );

  // ----------------------------------------------------------------
  // Fault reaction state machine
  // ----------------------------------------------------------------
  wire logic stopRetry;
  wire logic attemptsSpent;
  wire logic expired;
  assign stopRetry = offCommand | otherFaultShutdown;
  assign expired = tmrBus.expired;
  // Finite settings run out once the next failure reaches the count
  assign attemptsSpent = (retrySetting != RETRY_FOREVER) &&
                         ((attempts_r + 3'h1) >= retrySetting);

  always_comb begin
    state_nxt = state_r;
    attempts_nxt = attempts_r;
    timerStart = 1'b0;
    unique case (state_r)
      ST_RUN: begin
        attempts_nxt = 3'h0;
        if (inputLowFault_r) begin
          unique case (reactMode)
            MODE_IGNORE: begin
              state_nxt = ST_RUN;
            end
            MODE_RUN_THEN_RETRY: begin
              state_nxt = ST_CONTINUE;
              timerStart = 1'b1;
            end
            MODE_DISABLE_RETRY: begin
              if (retrySetting == RETRY_NONE) begin
                state_nxt = ST_LATCHED;
              end else begin
                state_nxt = ST_RETRY_WAIT;
                timerStart = 1'b1;
              end
            end
            MODE_DISABLE_RESUME: begin
              state_nxt = ST_RESUME_WAIT;
            end
          endcase
        end
      end
      ST_CONTINUE: begin
        if (expired) begin
          if (!inputLowFault_r) begin
            state_nxt = ST_RUN;
          end else if (retrySetting == RETRY_NONE) begin
            state_nxt = ST_LATCHED;
          end else begin
            state_nxt = ST_RETRY_WAIT;
            timerStart = 1'b1;
          end
        end
      end
      ST_RETRY_WAIT: begin
        if (stopRetry) begin
          state_nxt = ST_LATCHED;
        end else if (expired) begin
          if (!inputLowFault_r) begin
            state_nxt = ST_RUN;
          end else if (attemptsSpent) begin
            state_nxt = ST_LATCHED;
          end else begin
            // Next attempt starts a full delay after this one
            attempts_nxt = attempts_r + 3'h1;
            timerStart = 1'b1;
          end
        end
      end
      ST_LATCHED: begin
        if (faultClear) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RESUME_WAIT: begin
        if (!inputLowFault_r) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_LATCHED;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_RUN;
      attempts_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      attempts_r <= attempts_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire logic outputOff;
  assign outputOff = (state_r == ST_RETRY_WAIT) ||
                     (state_r == ST_LATCHED) ||
                     (state_r == ST_RESUME_WAIT);

  assign outputEnable = ~outputOff;
  assign inputLowWarning = inputLowWarning_r;
  assign inputLowFault = inputLowFault_r;
  assign hybridRatioRegulationActive = hybridRatioRegulationActive_r;
  assign retryActive = state_r == ST_RETRY_WAIT;
  assign retryAttemptCount = attempts_r;
  assign cmdRdata = cmdRdata_r;
  assign cmdRdValid = cmdRdValid_r;
  assign cmdUnsupported = cmdUnsupported_r;

endmodule : uvh_input_low_fault

// ---- uvh_input_low_fault_asserts.sv ----
// Port checks for the input undervoltage handler
`timescale 1ns/1ps
module uvh_input_low_fault_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Command port
  input wire logic cmdWrite,
  input wire logic cmdRead,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWdata,
  input wire logic cmdRdValid,
  input wire logic cmdUnsupported,
  // Control and status
  input wire logic hybridRatioRegulationEnable,
  input wire logic faultClear,
  input wire logic outputEnable,
  input wire logic inputLowWarning,
  input wire logic inputLowFault,
  input wire logic hybridRatioRegulationActive,
  input wire logic retryActive
);
  logic [7:0] react_r;
  wire known = cmdCode inside {8'h58, 8'h59, 8'h5a};

  // ----------------------------------------------------------------
  // Copy of the reaction byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      react_r <= 8'h00;
    end else if (cmdWrite && cmdCode == 8'h5a) begin
      react_r <= cmdWdata[7:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence faultRise;
    $rose(inputLowFault);
  endsequence
  sequence latchedOff;
    !outputEnable && !retryActive && !faultClear;
  endsequence

  chk_read_answer:
  assert property (cmdRead && known |=> cmdRdValid)
    else $error("read answer missing");
  chk_unknown_code:
  assert property ((cmdRead || cmdWrite) && !known |=> cmdUnsupported)
    else $error("unknown code not flagged");
  chk_unsup_cause:
  assert property (cmdUnsupported |-> !$past(known))
    else $error("spurious unsupported pulse");
  chk_hybrid_gate:
  assert property (hybridRatioRegulationActive ==
    (inputLowWarning && $past(hybridRatioRegulationEnable)))
    else $error("hybrid flag mismatch");
  chk_ignore_mode:
  assert property ($fell(outputEnable) |->
    $past(inputLowFault) && $past(react_r[7:6]) != 2'b00)
    else $error("output dropped without cause");
  chk_disable_now:
  assert property (faultRise ##0 react_r[7:6] == 2'b10 |=> !outputEnable)
    else $error("output not disabled at once");
  chk_resume_follow:
  assert property (react_r[7:6] == 2'b11 |=>
    outputEnable == !$past(inputLowFault))
    else $error("output not following fault");
  chk_retry_off:
  assert property (retryActive |-> !outputEnable)
    else $error("output on during retry wait");
  chk_latch_hold:
  assert property (latchedOff ##0 react_r[7] != react_r[6] |=> !outputEnable)
    else $error("latched off state left");
endmodule : uvh_input_low_fault_asserts

bind uvh_input_low_fault uvh_input_low_fault_asserts
  uvh_input_low_fault_asserts_i (.clk, .resetn, .cmdWrite, .cmdRead,
  .cmdCode, .cmdWdata, .cmdRdValid, .cmdUnsupported,
  .hybridRatioRegulationEnable, .faultClear, .outputEnable,
  .inputLowWarning, .inputLowFault, .hybridRatioRegulationActive,
  .retryActive);

// ---- uvh_host.sv ----
// Host model driving the command port
`timescale 1ns/1ps
module uvh_host (
  // Clock
  input wire logic clk,
  // Command out
  output logic cmdWrite,
  output logic cmdRead,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdWdata,
  // Answer in
  input wire logic [15:0] cmdRdata,
  input wire logic cmdRdValid,
  input wire logic cmdUnsupported
);
  initial begin
    cmdWrite = 1'b0;
    cmdRead = 1'b0;
    cmdCode = 8'h00;
    cmdWdata = 16'h0000;
  end
  // Released lines carry the inverse of the last value
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmdWrite <= 1'b1;
    cmdCode <= c;
    cmdWdata <= d;
    @(posedge clk);
    cmdWrite <= 1'b0;
    cmdCode <= ~c;
    cmdWdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [17:0] a);
    @(posedge clk);
    cmdRead <= 1'b1;
    cmdCode <= c;
    @(posedge clk);
    cmdRead <= 1'b0;
    cmdCode <= ~c;
    #1;
    a = {cmdRdValid, cmdUnsupported, cmdRdata};
  endtask : rd
endmodule : uvh_host

// ---- uvh_input_low_fault_bench.sv ----
// Self-checking bench for the input undervoltage handler
`timescale 1ns/1ps
module uvh_input_low_fault_bench;
  import uvh_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] vinMeas = 16'h7bff;
  logic [15:0] unit = 16'h0001;
  logic hrEn = 1'b0;
  logic offCmd = 1'b0;
  logic othFlt = 1'b0;
  logic fltClr = 1'b0;
  logic cmdWrite, cmdRead, cmdRdValid, cmdUnsupported;
  logic [7:0] cmdCode;
  logic [15:0] cmdWdata, cmdRdata;
  logic oe, warn, flt, hra, rAct;
  logic [2:0] tries;
  int bad_count = 0;
  int checks_done = 0;

  always #5 clk = ~clk;

  uvh_host uvh_host_i (.clk, .cmdWrite, .cmdRead, .cmdCode, .cmdWdata,
    .cmdRdata, .cmdRdValid, .cmdUnsupported);
  uvh_input_low_fault uvh_input_low_fault_i (.clk, .resetn, .cmdWrite,
    .cmdRead, .cmdCode, .cmdWdata, .cmdRdata, .cmdRdValid, .cmdUnsupported,
    .vinMeas, .timeUnitCycles(unit), .hybridRatioRegulationEnable(hrEn),
    .offCommand(offCmd), .otherFaultShutdown(othFlt), .faultClear(fltClr),
    .outputEnable(oe), .inputLowWarning(warn), .inputLowFault(flt),
    .hybridRatioRegulationActive(hra), .retryActive(rAct),
    .retryAttemptCount(tries));

  task automatic cmp(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_span(input string nm, input int lo, hi, g);
    checks_done++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : cmp_span
  function automatic longint lin(input logic [15:0] v);
    longint m;
    m = $signed(v[10:0]);
    return m <<< ($signed(v[15:11]) + 16);
  endfunction : lin
  task automatic rst;
    @(posedge clk);
    resetn <= 1'b0;
    vinMeas <= 16'h7bff;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask : rst
  task automatic setup(input logic [7:0] r);
    rst();
    uvh_host_i.wr(8'h58, 16'h0050);
    uvh_host_i.wr(8'h59, 16'h0032);
    uvh_host_i.wr(8'h5a, {8'h00, r});
  endtask : setup
  task automatic tally(input int n, output int on, act);
    on = 0;
    act = 0;
    repeat (n) begin
      @(posedge clk);
      on += int'(oe === 1'b1);
      act += int'(rAct === 1'b1);
    end
  endtask : tally
  task automatic clear;
    fltClr <= 1'b1;
    @(posedge clk);
    fltClr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : clear
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  initial begin
    logic [17:0] a;
    logic [15:0] w, f;
    int on, act, n;
    void'($urandom(32'ha155_7672));
    rst();
    for (int i = 0; i < 4; i++) begin
      uvh_host_i.rd(8'h58 + 8'(i), a);
      cmp("reset value", 16'h0000, a[15:0]);
      w = 16'($urandom);
      uvh_host_i.wr(8'h58 + 8'(i), w);
      uvh_host_i.rd(8'h58 + 8'(i), a);
      f = (i == 3) ? 16'h0000 : (i == 2) ? {8'h00, w[7:0]} : w;
      cmp("read back", f, a[15:0]);
      cmp("unsupported", 16'(i == 3), 16'(a[16]));
    end
    rst();
    for (int i = 0; i < 30; i++) begin
      w = 16'($urandom);
      f = 16'($urandom);
      uvh_host_i.wr(8'h58, w);
      uvh_host_i.wr(8'h59, f);
      vinMeas <= 16'($urandom);
      hrEn <= 1'($urandom);
      repeat (3) @(posedge clk);
      cmp("warning", 16'(lin(vinMeas) < lin(w)), 16'(warn));
      cmp("fault", 16'(lin(vinMeas) < lin(f)), 16'(flt));
      cmp("hybrid", 16'(lin(vinMeas) < lin(w) && hrEn), 16'(hra));
    end
    setup({2'b00, 6'($urandom)});
    vinMeas <= 16'h0014;
    tally(60, on, act);
    cmp_span("ignore on", 60, 60, on);
    setup({2'b11, 6'($urandom)});
    vinMeas <= 16'h0014;
    tally(100, on, act);
    cmp_span("resume off", 2, 2, on);
    vinMeas <= 16'h0064;
    tally(10, on, act);
    cmp_span("resume on", 8, 8, on);
    for (int k = 0; k < 7; k++) begin
      setup({2'b10, 3'(k), 3'(k)});
      vinMeas <= 16'h0014;
      n = k * (1 << k);
      tally(n + 20, on, act);
      cmp_span("disable on", 2, 2, on);
      cmp_span("retry time", n, n + k, act);
      vinMeas <= 16'h0064;
      repeat (4) @(posedge clk);
      cmp("stays off", 16'h0000, 16'(oe));
      clear();
      cmp("cleared on", 16'h0001, 16'(oe));
    end
    unit <= 16'h0002;
    setup(8'h4a);
    vinMeas <= 16'h0014;
    on = 0;
    while (oe === 1'b1 && on < 40) begin
      @(posedge clk);
      on++;
    end
    cmp_span("run delay", 8, 11, on);
    vinMeas <= 16'h0064;
    tally(12, on, act);
    cmp("retry success", 16'h0001, 16'(oe));
    unit <= 16'h0001;
    for (int k = 0; k < 2; k++) begin
      setup(8'hbf);
      vinMeas <= 16'h0014;
      tally(700, on, act);
      cmp_span("endless retry", 690, 700, act);
      cmp("attempt count", 16'h0005, 16'(tries));
      offCmd <= (k == 0);
      othFlt <= (k == 1);
      repeat (3) @(posedge clk);
      cmp("retry stopped", 16'h0000, 16'(rAct));
      offCmd <= 1'b0;
      othFlt <= 1'b0;
      vinMeas <= 16'h0064;
      repeat (3) @(posedge clk);
      cmp("held off", 16'h0000, 16'(oe));
      clear();
      cmp("clear on", 16'h0001, 16'(oe));
    end
    wrap_up();
  end

  // Watchdog, run needs under 10k cycles
  initial begin
    #200us;
    bad_count++;
    wrap_up();
  end
endmodule : uvh_input_low_fault_bench
